//--- bench/srt_timer_bench.sv
`timescale 1ns/1ns
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin error_cnt++; \
   $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
module srt_timer_bench;
   // bench-driven inputs
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic ext_osc = 1'b0;
   logic [11:0] aw_addr = 12'h000;
   logic [11:0] ar_addr = 12'h000;
   logic [31:0] w_data = 32'h0000_0000;
   logic aw_vld = 1'b0;
   logic w_vld = 1'b0;
   logic b_rdy = 1'b0;
   logic ar_vld = 1'b0;
   logic r_rdy = 1'b0;
   // design outputs
   logic aw_rdy, w_rdy, b_vld, ar_rdy, r_vld, irq;
   logic [1:0] b_resp, r_resp;
   logic [31:0] r_data;
   // bookkeeping
   int error_cnt = 0;
   int num_checks = 0;
   logic [3:0] osc_cnt = 4'h0;
   logic [7:0] rv;
   localparam logic [1:0] OK = srt_pkg::RESP_OKAY;

   srt_timer DUT (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(aw_addr), .s_axi_awprot(3'h0), .s_axi_awvalid(aw_vld),
      .s_axi_awready(aw_rdy), .s_axi_wdata(w_data), .s_axi_wstrb(4'hF),
      .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp),
      .s_axi_bvalid(b_vld), .s_axi_bready(b_rdy), .s_axi_araddr(ar_addr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(ar_vld), .s_axi_arready(ar_rdy),
      .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
      .s_axi_rready(r_rdy), .ext_osc(ext_osc), .irq(irq));

   initial begin
      forever #5 aclk = ~aclk;
   end

   // oscillator period of ten clocks, so one divided rising edge every 80 clocks
   always @(posedge aclk) begin
      osc_cnt <= (osc_cnt == 4'h4) ? 4'h0 : osc_cnt + 4'h1;
      if (osc_cnt == 4'h4) begin
         ext_osc <= ~ext_osc;
      end
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run

   function automatic logic [11:0] ad(input logic [7:0] idx);
      return {2'b00, idx, 2'b00};
   endfunction : ad

   // one clock with a bound on every handshake wait
   task automatic step(inout int n);
      @(posedge aclk);
      n++;
      if (n > 60) begin
         error_cnt++;
         $display("unexpected handshake wait expected 1 seen 0");
         complete_run();
      end
   endtask : step

   task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
      logic aw_ok = 1'b0;
      logic w_ok = 1'b0;
      int n = 0;
      aw_addr <= ad(idx);
      w_data <= {24'h00_0000, d};
      aw_vld <= 1'b1;
      w_vld <= 1'b1;
      while (!(aw_ok && w_ok)) begin
         step(n);
         if (!aw_ok && aw_rdy) begin
            aw_ok = 1'b1;
            aw_vld <= 1'b0;
         end
         if (!w_ok && w_rdy) begin
            w_ok = 1'b1;
            w_vld <= 1'b0;
         end
      end
      b_rdy <= 1'b1;
      do step(n); while (!b_vld);
      b_rdy <= 1'b0;
      `CHK("bresp", er, b_resp)
   endtask : wr

   task automatic rd(input logic [7:0] idx, input logic [1:0] er, output logic [7:0] d);
      int n = 0;
      ar_addr <= ad(idx);
      ar_vld <= 1'b1;
      do step(n); while (!ar_rdy);
      ar_vld <= 1'b0;
      r_rdy <= 1'b1;
      do step(n); while (!r_vld);
      r_rdy <= 1'b0;
      d = r_data[7:0];
      `CHK("rresp", er, r_resp)
   endtask : rd

   task automatic rchk(input logic [7:0] idx, input logic [7:0] ex, input string nm);
      logic [7:0] d;
      rd(idx, OK, d);
      `CHK(nm, ex, d)
   endtask : rchk

   task automatic t_reset();
      rchk(srt_pkg::IDX_CTRL, 8'h00, "control reset");
      rchk(srt_pkg::IDX_CNT_LO, 8'h00, "low count reset");
      rchk(srt_pkg::IDX_CNT_HI, 8'h00, "high count reset");
      `CHK("irq reset", 1'b0, irq)
   endtask : t_reset

   task automatic t_regs();
      wr(srt_pkg::IDX_RLD_LO, 8'h34, OK);
      wr(srt_pkg::IDX_RLD_HI, 8'h12, OK);
      wr(srt_pkg::IDX_CTRL, 8'h02, OK);
      rchk(srt_pkg::IDX_CTRL, 8'h00, "read-only zero bit");
      rchk(srt_pkg::IDX_RLD_LO, 8'h34, "low reload");
      rchk(srt_pkg::IDX_RLD_HI, 8'h12, "high reload");
      wr(8'h00, 8'h55, srt_pkg::RESP_SLVERR);
      rd(8'h01, srt_pkg::RESP_SLVERR, rv);
      `CHK("unmapped data", 8'h00, rv)
   endtask : t_regs

   // wrap from 0xFFF0 must land on the 0x1234 reload
   task automatic t_wide();
      wr(srt_pkg::IDX_CLK_SEL, 8'h01, OK);
      wr(srt_pkg::IDX_IRQ_MASK, 8'h01, OK);
      wr(srt_pkg::IDX_CNT_LO, 8'hF0, OK);
      wr(srt_pkg::IDX_CNT_HI, 8'hFF, OK);
      wr(srt_pkg::IDX_CTRL, 8'h04, OK);
      repeat (24) @(posedge aclk);
      rchk(srt_pkg::IDX_CTRL, 8'hC4, "wide overflow flags");
      `CHK("irq on wide overflow", 1'b1, irq)
      wr(srt_pkg::IDX_CTRL, 8'hC0, OK);
      rchk(srt_pkg::IDX_CNT_HI, 8'h12, "reloaded high count");
      rchk(srt_pkg::IDX_CTRL, 8'hC0, "flags kept");
      wr(srt_pkg::IDX_IRQ_STAT, 8'h01, OK);
      `CHK("irq after high clear", 1'b0, irq)
      wr(srt_pkg::IDX_IRQ_MASK, 8'h03, OK);
      wr(srt_pkg::IDX_CTRL, 8'h60, OK);
      `CHK("irq on low wrap", 1'b1, irq)
      wr(srt_pkg::IDX_IRQ_STAT, 8'h02, OK);
      `CHK("irq after low clear", 1'b0, irq)
   endtask : t_wide

   task automatic t_split();
      wr(srt_pkg::IDX_CLK_SEL, 8'h03, OK);
      wr(srt_pkg::IDX_RLD_LO, 8'h50, OK);
      wr(srt_pkg::IDX_RLD_HI, 8'h20, OK);
      wr(srt_pkg::IDX_CNT_LO, 8'hF8, OK);
      wr(srt_pkg::IDX_CNT_HI, 8'hFE, OK);
      wr(srt_pkg::IDX_CTRL, 8'h0C, OK);
      repeat (12) @(posedge aclk);
      rchk(srt_pkg::IDX_CTRL, 8'hCC, "split flags");
      wr(srt_pkg::IDX_CTRL, 8'hC8, OK);
      rd(srt_pkg::IDX_CNT_HI, OK, rv);
      `CHK("high byte reload", 3'b001, rv[7:5])
      rd(srt_pkg::IDX_CNT_LO, OK, rv);
      `CHK("low byte reload", 1'b1, rv >= 8'h50)
      `CHK("irq on high byte", 1'b1, irq)
      wr(srt_pkg::IDX_IRQ_STAT, 8'h01, OK);
      `CHK("low wrap without enable", 1'b0, irq)
      wr(srt_pkg::IDX_CTRL, 8'h68, OK);
      `CHK("low wrap with enable", 1'b1, irq)
   endtask : t_split

   // roughly 244 clocks of run time at one tick in twelve
   task automatic t_div12();
      wr(srt_pkg::IDX_CTRL, 8'h00, OK);
      wr(srt_pkg::IDX_CLK_SEL, 8'h00, OK);
      wr(srt_pkg::IDX_CNT_LO, 8'h00, OK);
      wr(srt_pkg::IDX_CNT_HI, 8'h00, OK);
      wr(srt_pkg::IDX_CTRL, 8'h04, OK);
      repeat (240) @(posedge aclk);
      wr(srt_pkg::IDX_CTRL, 8'h00, OK);
      rd(srt_pkg::IDX_CNT_LO, OK, rv);
      `CHK("divide by 12 count", 1'b1, rv >= 8'h13 && rv <= 8'h16)
   endtask : t_div12

   // split, run off, low byte on the divided oscillator
   task automatic t_ext();
      wr(srt_pkg::IDX_CNT_LO, 8'h00, OK);
      wr(srt_pkg::IDX_CNT_HI, 8'h77, OK);
      wr(srt_pkg::IDX_CTRL, 8'h09, OK);
      repeat (400) @(posedge aclk);
      rd(srt_pkg::IDX_CNT_LO, OK, rv);
      `CHK("oscillator by 8 count", 1'b1, rv >= 8'h04 && rv <= 8'h06)
      rchk(srt_pkg::IDX_CNT_HI, 8'h77, "high byte held");
   endtask : t_ext

   task automatic t_cap();
      wr(srt_pkg::IDX_CTRL, 8'h00, OK);
      wr(srt_pkg::IDX_CLK_SEL, 8'h01, OK);
      wr(srt_pkg::IDX_CNT_LO, 8'h00, OK);
      wr(srt_pkg::IDX_CNT_HI, 8'h00, OK);
      wr(srt_pkg::IDX_RLD_LO, 8'hCD, OK);
      wr(srt_pkg::IDX_RLD_HI, 8'hAB, OK);
      wr(srt_pkg::IDX_CTRL, 8'h14, OK);
      repeat (200) @(posedge aclk);
      rchk(srt_pkg::IDX_CTRL, 8'h94, "capture flag");
      wr(srt_pkg::IDX_CTRL, 8'h10, OK);
      rchk(srt_pkg::IDX_RLD_HI, 8'h00, "captured high");
      rd(srt_pkg::IDX_CNT_LO, OK, rv);
      `CHK("capture count clock", 2'b11, rv[7:6])
   endtask : t_cap

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_regs();
      t_wide();
      t_split();
      t_div12();
      t_ext();
      t_cap();
      complete_run();
   end
endmodule : srt_timer_bench

//--- verilog/srt_clk_src.sv
`timescale 1ns/1ns
module srt_clk_src (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // external oscillator
   input wire logic ext_osc,
   // count enables
   output srt_pkg::srt_ticks_t ticks
);
   typedef struct packed {
      logic sync1;
      logic sync2;
      logic sync3;
      logic [3:0] div_cnt;
      logic [2:0] ext_cnt;
      logic div12;
      logic ext_rise8;
      logic ext_fall8;
   } srt_clk_state_t;

   srt_clk_state_t st_r;
   srt_clk_state_t st_nxt;
   logic ext_rise;

   always_comb begin
      st_nxt = st_r;
      // two flops keep the oscillator edge off the timer's decision logic
      st_nxt.sync1 = ext_osc;
      st_nxt.sync2 = st_r.sync1;
      st_nxt.sync3 = st_r.sync2;
      ext_rise = st_r.sync2 & ~st_r.sync3;
      st_nxt.div12 = (st_r.div_cnt == srt_pkg::SYS_DIV_LAST);
      st_nxt.div_cnt = st_nxt.div12 ? 4'h0 : st_r.div_cnt + 4'h1;
      st_nxt.ext_rise8 = ext_rise & (st_r.ext_cnt == srt_pkg::EXT_RISE_AT);
      st_nxt.ext_fall8 = ext_rise & (st_r.ext_cnt == srt_pkg::EXT_FALL_AT);
      if (ext_rise) begin
         st_nxt.ext_cnt = st_r.ext_cnt + 3'h1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign ticks = '{sys_tick: 1'b1, div12_tick: st_r.div12,
                    ext_tick: st_r.ext_rise8, ext_fall: st_r.ext_fall8};

   // helper gap counter for the divide-by-12 check
   logic [3:0] gap_r;
   logic seen_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         gap_r <= 4'h0;
         seen_r <= 1'b0;
      end else if (st_r.div12) begin
         gap_r <= 4'h0;
         seen_r <= 1'b1;
      end else begin
         gap_r <= gap_r + 4'h1;
      end
   end

   div12_spacing_a: assert property (@(posedge aclk) disable iff (!aresetn)
      st_r.div12 && seen_r |-> gap_r == 4'hB)
      else $error("divide-by-12 tick spacing wrong");
   cover_ext_fall: cover property (@(posedge aclk) disable iff (!aresetn) st_r.ext_fall8);
endmodule : srt_clk_src

//--- verilog/srt_pkg.sv
// Summary of operation
// - count is 16 bits made of low and high count bytes, both software read/write
// - control bit 3 picks one 16-bit reload counter or two 8-bit reload counters
// - count clock is system clock, system clock /12, or synchronised external /8
// - 16-bit mode: wrap past 0xFFFF loads 16-bit reload value and sets high flag
// - 16-bit mode: timer interrupt enabled gives a request on every full overflow
// - 16-bit mode: low-byte interrupt enable adds requests on low byte 0xFF to 0x00; the code also needs interrupt mask bit 1 set
// - split mode: each byte reloads from its own reload byte
// - split mode: run bit gates only the high byte; low byte always counts
// - split mode: per-byte select 1 picks system clock, else external select decides
// - split mode: high byte wrap sets high flag, low byte wrap sets low flag
// - split mode: interrupt on high wrap, and on low wrap if low enable set; the code also needs interrupt mask bit 1 for the low wrap
// - hardware never clears the overflow flags; software clears and inspects both
// - capture mode clocks counter from system clock or system clock /12
// - capture: falling edge of external /8 copies count to reload, sets high flag
// - control register index 0x91 page 0x00, bit 1 reads zero, fixed bit layout
// - low flag set on every low byte wrap in either mode
package srt_pkg;
   localparam int ADDR_W = 12;
   // register indices; byte address is four times the index
   localparam logic [7:0] IDX_CLK_SEL = 8'h8E;
   localparam logic [7:0] IDX_CTRL = 8'h91;
   localparam logic [7:0] IDX_RLD_LO = 8'h92;
   localparam logic [7:0] IDX_RLD_HI = 8'h93;
   localparam logic [7:0] IDX_CNT_LO = 8'h94;
   localparam logic [7:0] IDX_CNT_HI = 8'h95;
   localparam logic [7:0] IDX_IRQ_STAT = 8'h96;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h97;
   localparam logic [7:0] SFR_PAGE = 8'h00;
   // control field positions
   localparam int CTRL_HIGH_FLAG = 7;
   localparam int CTRL_LOW_FLAG = 6;
   localparam int CTRL_LOW_IEN = 5;
   localparam int CTRL_CAPTURE = 4;
   localparam int CTRL_SPLIT = 3;
   localparam int CTRL_RUN = 2;
   localparam int CTRL_EXT_SEL = 0;
   localparam logic [7:0] CTRL_WMASK = 8'hFD;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // clock select, status and mask field positions
   localparam int SEL_LOW = 0;
   localparam int SEL_HIGH = 1;
   localparam int STAT_HIGH = 0;
   localparam int STAT_LOW = 1;
   // divider counts in cycles
   localparam int SYS_DIV = 12;
   localparam int EXT_DIV = 8;
   localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIV - 1);
   localparam logic [2:0] EXT_RISE_AT = 3'(EXT_DIV / 2 - 1);
   localparam logic [2:0] EXT_FALL_AT = 3'(EXT_DIV - 1);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef struct packed {
      logic sys_tick;
      logic div12_tick;
      logic ext_tick;
      logic ext_fall;
   } srt_ticks_t;
endpackage : srt_pkg

//--- verilog/srt_timer.sv
`timescale 1ns/1ns
module srt_timer (
   // clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // axi4-lite write address
   input wire logic [srt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // axi4-lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // axi4-lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // axi4-lite read address
   input wire logic [srt_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // axi4-lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // external oscillator
   input wire logic ext_osc,
   // interrupt request
   output logic irq
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [1:0] clk_sel;
      logic [7:0] rld_lo;
      logic [7:0] rld_hi;
      logic [7:0] cnt_lo;
      logic [7:0] cnt_hi;
      logic [1:0] mask;
      logic aw_full;
      logic aw_ok;
      logic [7:0] aw_idx;
      logic w_full;
      logic w_en;
      logic [7:0] w_data;
      logic b_valid;
      logic [1:0] b_resp;
      logic r_valid;
      logic [31:0] r_data;
      logic [1:0] r_resp;
   } srt_state_t;

   srt_state_t st_r;
   srt_state_t st_nxt;
   srt_pkg::srt_ticks_t ticks;

   logic do_wr;
   logic wr_ctrl;
   logic wr_clk_sel;
   logic wr_rld_lo;
   logic wr_rld_hi;
   logic wr_cnt_lo;
   logic wr_cnt_hi;
   logic wr_stat;
   logic wr_mask;
   logic lo_tick;
   logic hi_tick;
   logic tick16;
   logic hf_set;
   logic lf_set;
   logic split;
   logic capture;
   logic run;
   logic [15:0] count16;

   srt_clk_src u_clk_src (
      .aclk(aclk),
      .aresetn(aresetn),
      .ext_osc(ext_osc),
      .ticks(ticks)
   );

   function automatic logic reg_hit(input logic [srt_pkg::ADDR_W-1:0] a);
      logic [7:0] idx;
      idx = a[9:2];
      reg_hit = (a[11:10] == 2'h0) && (a[1:0] == 2'h0) &&
                (idx inside {srt_pkg::IDX_CLK_SEL, srt_pkg::IDX_CTRL, srt_pkg::IDX_RLD_LO,
                             srt_pkg::IDX_RLD_HI, srt_pkg::IDX_CNT_LO, srt_pkg::IDX_CNT_HI,
                             srt_pkg::IDX_IRQ_STAT, srt_pkg::IDX_IRQ_MASK});
   endfunction : reg_hit

   // per-byte clock source: system clock, or whatever the external select picks
   function automatic logic sel_tick_src(input logic byte_sel, input logic ext_sel,
                                         input srt_pkg::srt_ticks_t t);
      if (byte_sel) begin
         sel_tick_src = t.sys_tick;
      end else begin
         sel_tick_src = ext_sel ? t.ext_tick : t.div12_tick;
      end
   endfunction : sel_tick_src

   assign split = st_r.ctrl[srt_pkg::CTRL_SPLIT];
   assign capture = st_r.ctrl[srt_pkg::CTRL_CAPTURE];
   assign run = st_r.ctrl[srt_pkg::CTRL_RUN];
   assign count16 = {st_r.cnt_hi, st_r.cnt_lo};

   // register write strobes
   always_comb begin
      do_wr = st_r.aw_full & st_r.w_full & ~st_r.b_valid;
      wr_ctrl = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_CTRL);
      wr_clk_sel = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_CLK_SEL);
      wr_rld_lo = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_RLD_LO);
      wr_rld_hi = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_RLD_HI);
      wr_cnt_lo = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_CNT_LO);
      wr_cnt_hi = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_CNT_HI);
      wr_stat = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_IRQ_STAT);
      wr_mask = do_wr & st_r.aw_ok & st_r.w_en & (st_r.aw_idx == srt_pkg::IDX_IRQ_MASK);
   end

   // count enables per byte
   always_comb begin
      lo_tick = sel_tick_src(st_r.clk_sel[srt_pkg::SEL_LOW],
                             st_r.ctrl[srt_pkg::CTRL_EXT_SEL], ticks);
      hi_tick = sel_tick_src(st_r.clk_sel[srt_pkg::SEL_HIGH],
                             st_r.ctrl[srt_pkg::CTRL_EXT_SEL], ticks);
      // capture measures the oscillator, so it never counts on the oscillator itself
      if (capture) begin
         tick16 = st_r.clk_sel[srt_pkg::SEL_LOW] ? ticks.sys_tick : ticks.div12_tick;
      end else begin
         tick16 = lo_tick;
      end
   end

   always_comb begin
      st_nxt = st_r;
      hf_set = 1'b0;
      lf_set = 1'b0;

      // counting first, so that a software write in the same cycle overrides it
      if (!split) begin
         if (run && tick16) begin
            if (count16 == 16'hFFFF) begin
               {st_nxt.cnt_hi, st_nxt.cnt_lo} = {st_r.rld_hi, st_r.rld_lo};
               hf_set = 1'b1;
               lf_set = 1'b1;
            end else begin
               {st_nxt.cnt_hi, st_nxt.cnt_lo} = count16 + 16'h0001;
               lf_set = (st_r.cnt_lo == 8'hFF);
            end
         end
         // the value captured is the count before any increment this cycle
         if (capture && ticks.ext_fall) begin
            {st_nxt.rld_hi, st_nxt.rld_lo} = count16;
            hf_set = 1'b1;
         end
      end else begin
         if (lo_tick) begin
            if (st_r.cnt_lo == 8'hFF) begin
               st_nxt.cnt_lo = st_r.rld_lo;
               lf_set = 1'b1;
            end else begin
               st_nxt.cnt_lo = st_r.cnt_lo + 8'h01;
            end
         end
         if (run && hi_tick) begin
            if (st_r.cnt_hi == 8'hFF) begin
               st_nxt.cnt_hi = st_r.rld_hi;
               hf_set = 1'b1;
            end else begin
               st_nxt.cnt_hi = st_r.cnt_hi + 8'h01;
            end
         end
      end

      // software writes
      if (wr_ctrl) begin
         st_nxt.ctrl = st_r.w_data & srt_pkg::CTRL_WMASK;
      end
      if (wr_clk_sel) begin
         st_nxt.clk_sel = st_r.w_data[1:0];
      end
      if (wr_rld_lo) begin
         st_nxt.rld_lo = st_r.w_data;
      end
      if (wr_rld_hi) begin
         st_nxt.rld_hi = st_r.w_data;
      end
      if (wr_cnt_lo) begin
         st_nxt.cnt_lo = st_r.w_data;
      end
      if (wr_cnt_hi) begin
         st_nxt.cnt_hi = st_r.w_data;
      end
      if (wr_mask) begin
         st_nxt.mask = st_r.w_data[1:0];
      end
      if (wr_stat) begin
         st_nxt.ctrl[srt_pkg::CTRL_HIGH_FLAG] = st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG] &
                                                ~st_r.w_data[srt_pkg::STAT_HIGH];
         st_nxt.ctrl[srt_pkg::CTRL_LOW_FLAG] = st_r.ctrl[srt_pkg::CTRL_LOW_FLAG] &
                                               ~st_r.w_data[srt_pkg::STAT_LOW];
      end
      // hardware events set the flags only here; a same-cycle clear loses to a new event
      st_nxt.ctrl[srt_pkg::CTRL_HIGH_FLAG] = st_nxt.ctrl[srt_pkg::CTRL_HIGH_FLAG] | hf_set;
      st_nxt.ctrl[srt_pkg::CTRL_LOW_FLAG] = st_nxt.ctrl[srt_pkg::CTRL_LOW_FLAG] | lf_set;

      // write channels, taken in either order
      if (s_axi_awvalid && s_axi_awready) begin
         st_nxt.aw_full = 1'b1;
         st_nxt.aw_idx = s_axi_awaddr[9:2];
         st_nxt.aw_ok = reg_hit(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
         st_nxt.w_full = 1'b1;
         st_nxt.w_data = s_axi_wdata[7:0];
         st_nxt.w_en = s_axi_wstrb[0];
      end
      if (do_wr) begin
         st_nxt.aw_full = 1'b0;
         st_nxt.w_full = 1'b0;
         st_nxt.b_valid = 1'b1;
         st_nxt.b_resp = st_r.aw_ok ? srt_pkg::RESP_OKAY : srt_pkg::RESP_SLVERR;
      end else if (st_r.b_valid && s_axi_bready) begin
         st_nxt.b_valid = 1'b0;
      end

      // read channel; unmapped reads return zero with an error
      if (s_axi_arvalid && s_axi_arready) begin
         st_nxt.r_valid = 1'b1;
         st_nxt.r_data = 32'h0000_0000;
         st_nxt.r_resp = reg_hit(s_axi_araddr) ? srt_pkg::RESP_OKAY : srt_pkg::RESP_SLVERR;
         if (reg_hit(s_axi_araddr)) begin
            case (s_axi_araddr[9:2])
               srt_pkg::IDX_CLK_SEL: st_nxt.r_data[1:0] = st_r.clk_sel;
               srt_pkg::IDX_CTRL: st_nxt.r_data[7:0] = st_r.ctrl;
               srt_pkg::IDX_RLD_LO: st_nxt.r_data[7:0] = st_r.rld_lo;
               srt_pkg::IDX_RLD_HI: st_nxt.r_data[7:0] = st_r.rld_hi;
               srt_pkg::IDX_CNT_LO: st_nxt.r_data[7:0] = st_r.cnt_lo;
               srt_pkg::IDX_CNT_HI: st_nxt.r_data[7:0] = st_r.cnt_hi;
               srt_pkg::IDX_IRQ_STAT: st_nxt.r_data[1:0] = {st_r.ctrl[srt_pkg::CTRL_LOW_FLAG],
                                                          st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG]};
               srt_pkg::IDX_IRQ_MASK: st_nxt.r_data[1:0] = st_r.mask;
               default: st_nxt.r_data = 32'h0000_0000;
            endcase
         end
      end else if (st_r.r_valid && s_axi_rready) begin
         st_nxt.r_valid = 1'b0;
      end
   end

   // reset leaves control at its documented zero value
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign s_axi_awready = ~st_r.aw_full & ~st_r.b_valid;
   assign s_axi_wready = ~st_r.w_full & ~st_r.b_valid;
   assign s_axi_bvalid = st_r.b_valid;
   assign s_axi_bresp = st_r.b_resp;
   assign s_axi_arready = ~st_r.r_valid;
   assign s_axi_rvalid = st_r.r_valid;
   assign s_axi_rdata = st_r.r_data;
   assign s_axi_rresp = st_r.r_resp;

   // mask bit 0 is the timer interrupt enable, bit 1 further gates the low byte
   assign irq = st_r.mask[srt_pkg::STAT_HIGH] &
                (st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG] |
                 (st_r.ctrl[srt_pkg::CTRL_LOW_FLAG] & st_r.ctrl[srt_pkg::CTRL_LOW_IEN] &
                  st_r.mask[srt_pkg::STAT_LOW]));

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   overflow_reload_a: assert property (
      !split && run && tick16 && count16 == 16'hFFFF && !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl
      |=> count16 == $past({st_r.rld_hi, st_r.rld_lo}) && st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG])
      else $error("16-bit overflow did not reload or flag");
   high_irq_a: assert property (
      st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG] && st_r.mask[srt_pkg::STAT_HIGH] |-> irq)
      else $error("high flag enabled but no interrupt");
   low_irq_a: assert property (
      st_r.ctrl[srt_pkg::CTRL_LOW_FLAG] && st_r.ctrl[srt_pkg::CTRL_LOW_IEN] &&
      (st_r.mask == 2'h3) |-> irq)
      else $error("low flag enabled but no interrupt");
   split_low_free_a: assert property (
      split && !run && lo_tick && st_r.cnt_lo != 8'hFF && !wr_cnt_lo && !wr_ctrl
      |=> st_r.cnt_lo == $past(st_r.cnt_lo) + 8'h01)
      else $error("split low byte did not count");
   split_high_hold_a: assert property (
      split && !run && !wr_cnt_hi && !wr_ctrl |=> $stable(st_r.cnt_hi))
      else $error("split high byte counted while stopped");
   split_low_reload_a: assert property (
      split && lo_tick && st_r.cnt_lo == 8'hFF && !wr_cnt_lo && !wr_ctrl && !wr_stat
      |=> st_r.cnt_lo == $past(st_r.rld_lo) && st_r.ctrl[srt_pkg::CTRL_LOW_FLAG])
      else $error("split low byte did not reload and flag");
   flag_sticky_a: assert property (
      st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG] && !wr_ctrl && !wr_stat
      |=> st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG])
      else $error("high flag cleared without software");
   capture_copy_a: assert property (
      !split && capture && ticks.ext_fall && !wr_rld_lo && !wr_rld_hi && !wr_ctrl
      |=> {st_r.rld_hi, st_r.rld_lo} == $past(count16) && st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG])
      else $error("capture did not copy count");
   zero_bit_a: assert property (
      s_axi_arvalid && s_axi_arready && s_axi_araddr[9:2] == srt_pkg::IDX_CTRL
      |=> s_axi_rvalid && !s_axi_rdata[1])
      else $error("control bit 1 read as one");
   irq_drop_a: assert property (
      !st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG] && !st_r.ctrl[srt_pkg::CTRL_LOW_FLAG] |-> !irq)
      else $error("interrupt without any flag");
   // software writes win over counting in the same cycle, hence the exclusions
   wide_count_a: assert property (
      !split && run && tick16 && count16 != 16'hFFFF && !wr_cnt_lo && !wr_cnt_hi && !wr_ctrl
      |=> count16 == $past(count16) + 16'h0001)
      else $error("16-bit count did not step as one counter");
   wide_low_flag_a: assert property (
      !split && run && tick16 && st_r.cnt_lo == 8'hFF && !wr_ctrl && !wr_stat
      |=> st_r.ctrl[srt_pkg::CTRL_LOW_FLAG])
      else $error("low byte wrap did not set low flag");
   split_high_reload_a: assert property (
      split && run && hi_tick && st_r.cnt_hi == 8'hFF && !wr_cnt_hi && !wr_ctrl && !wr_stat
      |=> st_r.cnt_hi == $past(st_r.rld_hi) && st_r.ctrl[srt_pkg::CTRL_HIGH_FLAG])
      else $error("split high byte did not reload and flag");
   resp_hold_a: assert property (
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");

   cover_overflow: cover property (!split && run && tick16 && count16 == 16'hFFFF);
   cover_split_high: cover property (split && run && hi_tick && st_r.cnt_hi == 8'hFF);
   cover_capture: cover property (capture && ticks.ext_fall);
   cover_irq: cover property (!irq ##1 irq);
endmodule : srt_timer
